// file: lpm_pkg.sv
/*
 * Constants and types for the low-power mode sequencer.
 * Assumes a single 50 MHz core clock; all timing counts derive from it.
 */
package lpm_pkg;

    localparam int unsigned CLK_FREQ_KHZ = 50_000;

    // Exit latencies and pacing, in nanoseconds
    localparam int unsigned STOP_WAKE_NS    = 3_500;
    localparam int unsigned STANDBY_WAKE_NS = 60_000;
    localparam int unsigned FREQ_GAP_NS     = 5_000;

    // Longest times round down, least times round up
    localparam int unsigned STOP_WAKE_CYC =
        (STOP_WAKE_NS * (CLK_FREQ_KHZ / 1000)) / 1000;
    localparam int unsigned STANDBY_WAKE_CYC =
        (STANDBY_WAKE_NS * (CLK_FREQ_KHZ / 1000)) / 1000;
    localparam int unsigned FREQ_GAP_CYC =
        (FREQ_GAP_NS * (CLK_FREQ_KHZ / 1000) + 999) / 1000;

    localparam int CNT_W = 12;

    // Frequency limits in kHz
    localparam int unsigned LP_RUN_MAX_KHZ = 131;
    localparam int unsigned RANGE1_MAX_KHZ = 32_000;
    localparam int unsigned RANGE2_MAX_KHZ = 16_000;
    localparam int unsigned RANGE3_MAX_KHZ = 4_200;
    localparam int unsigned FREQ_STEP_MUL  = 4;
    localparam int FREQ_W = 16;

    localparam int NUM_LINES     = 16;
    localparam int NUM_WAKE_PINS = 3;

    // Requested mode codes
    typedef enum logic [2:0] {
        LPM_REQ_SLEEP,
        LPM_REQ_LP_RUN,
        LPM_REQ_LP_SLEEP,
        LPM_REQ_STOP_CAL,
        LPM_REQ_STOP,
        LPM_REQ_STANDBY_CAL,
        LPM_REQ_STANDBY,
        LPM_REQ_NONE
    } lpm_req_t;

    typedef enum logic [1:0] {
        LPM_RANGE_1,
        LPM_RANGE_2,
        LPM_RANGE_3,
        LPM_RANGE_BAD
    } lpm_range_t;

    typedef enum logic [3:0] {
        ST_RUN,
        ST_SLEEP,
        ST_LP_RUN,
        ST_LP_SLEEP,
        ST_STOP_CAL,
        ST_STOP,
        ST_STANDBY_CAL,
        ST_STANDBY,
        ST_STOP_EXIT,
        ST_STANDBY_EXIT
    } lpm_state_t;

    function automatic logic [FREQ_W-1:0] lpm_range_max(lpm_range_t r);
        unique case (r)
            LPM_RANGE_1: lpm_range_max = FREQ_W'(RANGE1_MAX_KHZ);
            LPM_RANGE_2: lpm_range_max = FREQ_W'(RANGE2_MAX_KHZ);
            LPM_RANGE_3: lpm_range_max = FREQ_W'(RANGE3_MAX_KHZ);
            default:     lpm_range_max = FREQ_W'(RANGE3_MAX_KHZ);
        endcase
    endfunction

endpackage

// file: lpm_sequencer.sv
/*
 * Low-power mode sequencer: picks the power mode, drives clock,
 * oscillator and regulator enables, gathers wake sources, times
 * exits and paces CPU frequency changes.
 * Assumes pin/line wake sources are asynchronous; core requests and
 * the peripheral interrupt are synchronous to core_clk_in.
 */
// What this block does
// RQ1: Sleep halts only core; any interrupt wakes
// RQ2: Low-power run uses slow multispeed osc
// RQ3: Low-power sleep wakes to Run, regulator normal
// RQ4: Stop with calendar keeps low-speed osc only
// RQ5: Stop without calendar stops all clocks
// RQ6: Wake-capable peripheral may request fast osc
// RQ7: Interrupt line wakes Stop within 3.5 us
// RQ8: Comparator wake only with reference on
// RQ9: Standby turns regulator off, core unpowered
// RQ10: Standby-calendar exits on listed sources, 60 us
// RQ11: Standby exits on reset pin or wake pin
// RQ12: Calendar, watchdog, display not auto-stopped
// RQ13: Voltage range bounds CPU clock frequency
// RQ14: Frequency steps under 4x, 5 us apart
// RQ15: Standby wake resets; Stop wake resumes
module lpm_sequencer
    import lpm_pkg::*;
(
    input  wire logic                   core_clk_in,
    input  wire logic                   srst_in,
    input  wire logic                   clk_en_in,
    input  wire logic [2:0]             mode_req_in,
    input  wire logic                   mode_go_in,
    input  wire logic                   periph_irq_in,
    input  wire logic [NUM_LINES-1:0]   external_interrupt_line_in,
    input  wire logic [1:0]             comparator_event_in,
    input  wire logic                   vref_enabled_in,
    input  wire logic [NUM_WAKE_PINS-1:0] wake_pin_in,
    input  wire logic                   external_reset_pin_n_in,
    input  wire logic                   independent_watchdog_rst_in,
    input  wire logic [4:0]             calendar_event_in,
    input  wire logic                   hsi_periph_req_in,
    input  wire logic [1:0]             range_sel_in,
    input  wire logic [FREQ_W-1:0]      freq_req_khz_in,
    input  wire logic                   freq_go_in,
    output logic [3:0]                  mode_out,
    output logic                        core_clk_en_out,
    output logic                        periph_clk_en_out,
    output logic                        multispeed_internal_osc_en_out,
    output logic                        msi_low_speed_out,
    output logic                        high_speed_internal_osc_en_out,
    output logic                        high_speed_crystal_osc_en_out,
    output logic                        pll_en_out,
    output logic                        low_speed_osc_en_out,
    output logic                        reg_low_power_out,
    output logic                        reg_off_out,
    output logic                        core_retain_out,
    output logic                        standby_keep_out,
    output logic                        wake_reset_out,
    output logic                        wake_resume_out,
    output logic [FREQ_W-1:0]           cpu_freq_khz_out,
    output logic                        freq_busy_out,
    output logic                        freq_reject_out
);
    // Two synchroniser stages and the entry edge come before the exit
    // count, so the count is shortened to keep the total in the limit
    localparam int unsigned WAKE_OVH = 3;
    localparam logic [CNT_W-1:0] STOP_LEN =
        CNT_W'(STOP_WAKE_CYC - WAKE_OVH);
    localparam logic [CNT_W-1:0] SBY_LEN  =
        CNT_W'(STANDBY_WAKE_CYC - WAKE_OVH);
    localparam logic [CNT_W-1:0] STOP_CNT = STOP_LEN - CNT_W'(1);
    localparam logic [CNT_W-1:0] SBY_CNT  = SBY_LEN - CNT_W'(1);
    // Busy covers the full spacing, so the next step lands no earlier
    localparam logic [CNT_W-1:0] GAP_CNT  = CNT_W'(FREQ_GAP_CYC);
    localparam int SYNC_W = NUM_LINES + 2 + NUM_WAKE_PINS + 2 + 5;

    typedef struct packed {
        lpm_state_t             state;
        logic [CNT_W-1:0]       wcnt;
        logic [CNT_W-1:0]       exit_age;
        logic [CNT_W-1:0]       gap;
        logic [NUM_WAKE_PINS-1:0] pin_prev;
        logic [FREQ_W-1:0]      freq;
        logic                   reset_p;
        logic                   resume_p;
        logic                   reject_p;
    } lpm_st_t;

    lpm_st_t st;
    lpm_st_t next_st;

    logic [SYNC_W-1:0] s;
    logic [NUM_LINES-1:0] line_s;
    logic [1:0]           cmp_s;
    logic [NUM_WAKE_PINS-1:0] pin_s;
    logic rst_pin_s;
    logic wdg_s;
    logic [4:0] cal_s;
    logic irq_s;
    logic hsi_s;
    logic stop_wake;
    logic pin_rise;
    logic sby_cal_wake;
    logic sby_wake;
    logic freq_ok;

    // Reset pin enters inverted so the cleared synchroniser reads idle
    lpm_sync #(.W(SYNC_W)) u_sync (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .clk_en_in   (clk_en_in),
        .async_in    ({external_interrupt_line_in, comparator_event_in,
                       wake_pin_in, ~external_reset_pin_n_in,
                       independent_watchdog_rst_in, calendar_event_in}),
        .sync_out    (s)
    );
    assign {line_s, cmp_s, pin_s, rst_pin_s, wdg_s, cal_s} = s;
    // Same-domain inputs need no synchroniser
    assign irq_s = periph_irq_in;
    assign hsi_s = hsi_periph_req_in;

    function automatic lpm_state_t req_state(lpm_req_t r);
        unique case (r)
            LPM_REQ_SLEEP:       req_state = ST_SLEEP;
            LPM_REQ_LP_RUN:      req_state = ST_LP_RUN;
            LPM_REQ_LP_SLEEP:    req_state = ST_LP_SLEEP;
            LPM_REQ_STOP_CAL:    req_state = ST_STOP_CAL;
            LPM_REQ_STOP:        req_state = ST_STOP;
            LPM_REQ_STANDBY_CAL: req_state = ST_STANDBY_CAL;
            LPM_REQ_STANDBY:     req_state = ST_STANDBY;
            default:             req_state = ST_RUN;
        endcase
    endfunction

    // Comparator events count only with the reference on
    assign stop_wake = (|line_s) |
                       (vref_enabled_in & (|cmp_s)); // [RQ7] [RQ8]
    assign pin_rise  = |(pin_s & ~st.pin_prev);
    assign sby_wake  = rst_pin_s | pin_rise; // [RQ11]
    assign sby_cal_wake = sby_wake | wdg_s | (|cal_s); // [RQ10]

    // Step must keep initial below four times final, within range
    assign freq_ok = (st.gap == '0) &&
        (freq_req_khz_in <= lpm_range_max(lpm_range_t'(range_sel_in))) &&
        ({2'h0, st.freq} <
         FREQ_STEP_MUL * {2'h0, freq_req_khz_in}); // [RQ13] [RQ14]

    always_comb begin
        next_st = st;
        next_st.pin_prev = pin_s;
        next_st.reset_p  = 1'b0;
        next_st.resume_p = 1'b0;
        next_st.reject_p = 1'b0;
        // Free count of exit cycles, held against the exit limits
        if (st.state == ST_STOP_EXIT || st.state == ST_STANDBY_EXIT) begin
            next_st.exit_age = st.exit_age + CNT_W'(1);
        end else begin
            next_st.exit_age = '0;
        end
        if (st.gap != '0) begin
            next_st.gap = st.gap - CNT_W'(1);
        end
        if (freq_go_in) begin
            if (freq_ok) begin
                next_st.freq = freq_req_khz_in;
                next_st.gap  = GAP_CNT; // [RQ14]
            end else begin
                next_st.reject_p = 1'b1;
            end
        end
        unique case (st.state)
            ST_RUN: begin
                if (mode_go_in) begin
                    next_st.state = req_state(lpm_req_t'(mode_req_in));
                end
            end
            ST_SLEEP, ST_LP_SLEEP: begin
                if (irq_s || stop_wake) begin
                    next_st.state = ST_RUN; // [RQ1] [RQ3]
                end
            end
            ST_LP_RUN: begin
                if (mode_go_in) begin
                    next_st.state = ST_RUN;
                end
            end
            ST_STOP_CAL, ST_STOP: begin
                if (stop_wake) begin
                    next_st.state = ST_STOP_EXIT;
                    next_st.wcnt  = STOP_CNT; // [RQ7]
                end
            end
            ST_STANDBY_CAL: begin
                if (sby_cal_wake) begin
                    next_st.state = ST_STANDBY_EXIT;
                    next_st.wcnt  = SBY_CNT; // [RQ10]
                end
            end
            ST_STANDBY: begin
                if (sby_wake) begin
                    next_st.state = ST_STANDBY_EXIT;
                    next_st.wcnt  = SBY_CNT; // [RQ11]
                end
            end
            ST_STOP_EXIT: begin
                if (st.wcnt == '0) begin
                    next_st.state    = ST_RUN;
                    next_st.resume_p = 1'b1; // [RQ15]
                end else begin
                    next_st.wcnt = st.wcnt - CNT_W'(1);
                end
            end
            ST_STANDBY_EXIT: begin
                if (st.wcnt == '0) begin
                    next_st.state   = ST_RUN;
                    next_st.reset_p = 1'b1; // [RQ15]
                end else begin
                    next_st.wcnt = st.wcnt - CNT_W'(1);
                end
            end
            default: next_st.state = ST_RUN;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st       <= '0;
            st.state <= ST_RUN;
            st.freq  <= FREQ_W'(RANGE3_MAX_KHZ);
        end else if (clk_en_in) begin
            st <= next_st;
        end
    end

    logic in_stop;
    logic in_sby;
    logic stop_cal;
    assign stop_cal = st.state == ST_STOP_CAL;
    assign in_stop  = stop_cal || st.state == ST_STOP ||
                      st.state == ST_STOP_EXIT;
    assign in_sby   = st.state == ST_STANDBY_CAL ||
                      st.state == ST_STANDBY || st.state == ST_STANDBY_EXIT;

    assign mode_out          = st.state;
    assign core_clk_en_out   = st.state == ST_RUN ||
                               st.state == ST_LP_RUN; // [RQ1]
    assign periph_clk_en_out = !(in_stop || in_sby); // [RQ1] [RQ4] [RQ5]
    assign multispeed_internal_osc_en_out = !(in_stop || in_sby); // [RQ4]
    assign msi_low_speed_out = st.state == ST_LP_RUN ||
                               st.state == ST_LP_SLEEP; // [RQ2]
    assign high_speed_internal_osc_en_out = in_stop ? hsi_s : !in_sby; // [RQ6]
    assign high_speed_crystal_osc_en_out =
        !(in_stop || in_sby || msi_low_speed_out); // [RQ4]
    assign pll_en_out = !(in_stop || in_sby || msi_low_speed_out); // [RQ4]
    // Stop-without-calendar stops the slow oscillators; standby keeps them
    assign low_speed_osc_en_out = !(st.state == ST_STOP); // [RQ5] [RQ12]
    assign reg_low_power_out = msi_low_speed_out ||
                               in_stop; // [RQ2] [RQ3] [RQ5]
    assign reg_off_out       = in_sby; // [RQ9]
    assign core_retain_out   = !in_sby; // [RQ4] [RQ9]
    assign standby_keep_out  = 1'b1; // [RQ9] [RQ12]
    assign wake_reset_out    = st.reset_p;
    assign wake_resume_out   = st.resume_p;
    assign cpu_freq_khz_out  = st.freq;
    assign freq_busy_out     = st.gap != '0;
    assign freq_reject_out   = st.reject_p;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in || !clk_en_in);

    a_stop_wake_time: assert property ( // [RQ7]
        (st.state == ST_STOP && stop_wake) |=> st.state == ST_STOP_EXIT
        ##[171:173] wake_resume_out) else $error("stop wake too slow");
    a_stop_exit_len: assert property ( // [RQ7]
        wake_resume_out |-> st.exit_age == STOP_LEN)
        else $error("stop exit time wrong");
    a_cmp_needs_ref: assert property ( // [RQ8]
        (st.state == ST_STOP && !vref_enabled_in && !(|line_s))
        |=> st.state == ST_STOP) else $error("comparator woke stop");
    a_sby_wake_time: assert property ( // [RQ11]
        (st.state == ST_STANDBY && sby_wake) |=> st.state == ST_STANDBY_EXIT)
        else $error("standby exit wrong");
    a_sby_exit_len: assert property ( // [RQ10] [RQ11]
        wake_reset_out |-> st.exit_age == SBY_LEN)
        else $error("standby exit time wrong");
    a_sby_stays: assert property ( // [RQ11]
        (st.state == ST_STANDBY && !sby_wake) |=> st.state == ST_STANDBY)
        else $error("standby left without wake");
    a_sby_reg_off: assert property ( // [RQ9]
        in_sby |-> reg_off_out && !core_retain_out) else $error("reg on");
    a_sleep_core: assert property ( // [RQ1]
        st.state == ST_SLEEP |-> !core_clk_en_out && periph_clk_en_out)
        else $error("sleep clocks wrong");
    a_lp_sleep_ret: assert property ( // [RQ3]
        (st.state == ST_LP_SLEEP && irq_s) |=> st.state == ST_RUN
        && !reg_low_power_out) else $error("lp sleep exit wrong");
    a_lp_run_osc: assert property ( // [RQ2]
        st.state == ST_LP_RUN |-> msi_low_speed_out && reg_low_power_out
        && !pll_en_out) else $error("lp run clocks wrong");
    a_stop_clocks: assert property ( // [RQ4]
        stop_cal |-> low_speed_osc_en_out && !pll_en_out &&
        !high_speed_crystal_osc_en_out) else $error("stop clocks wrong");
    a_freq_gap: assert property ( // [RQ14]
        $changed(cpu_freq_khz_out) |-> freq_busy_out [*8])
        else $error("freq gap short");
    a_freq_range: assert property ( // [RQ13]
        $changed(cpu_freq_khz_out) |-> cpu_freq_khz_out <=
        lpm_range_max(lpm_range_t'($past(range_sel_in))))
        else $error("freq over range");

    c_stop_exit: cover property (wake_resume_out);
    c_sby_exit: cover property (wake_reset_out);
    c_sleep_wake: cover property (st.state == ST_SLEEP ##1 st.state == ST_RUN);
    c_freq_rej: cover property (freq_reject_out);
    c_lp_run: cover property (st.state == ST_LP_RUN);
endmodule

// file: lpm_src.sv
/*
 * Wakeup source model: drives one chosen wakeup source at a time.
 * Assumes the bench picks the source and its level at falling edges.
 */
module lpm_src
    import lpm_pkg::*;
(
    input  wire logic [2:0]           sel_in,
    input  wire logic                 act_in,
    output logic [NUM_LINES-1:0]      line_out,
    output logic [1:0]                cmp_out,
    output logic [NUM_WAKE_PINS-1:0]  pin_out,
    output logic                      rst_n_out,
    output logic                      wdg_out,
    output logic [4:0]                cal_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle sources sit inactive; the reset pin idles high
    always_comb begin
        line_out  = '0;
        cmp_out   = 2'h0;
        pin_out   = '0;
        rst_n_out = 1'b1;
        wdg_out   = 1'b0;
        cal_out   = 5'h00;
        if (act_in) begin
            case (sel_in)
                3'h0: line_out[5] = 1'b1;
                3'h1: cmp_out = 2'h3;
                3'h2: pin_out[2] = 1'b1;
                3'h3: rst_n_out = 1'b0;
                3'h4: wdg_out = 1'b1;
                3'h5: cal_out = 5'h10;
                default: ;
            endcase
        end
    end
endmodule

// file: lpm_sync.sv
/*
 * Two-flop synchroniser for a bus of asynchronous levels.
 * Assumes inputs come from pins or other clocks.
 */
module lpm_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_in,
    input  wire logic         srst_in,
    input  wire logic         clk_en_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } lpm_sync_st_t;

    lpm_sync_st_t st;
    lpm_sync_st_t next_st;

    always_comb begin
        next_st.meta   = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st <= '0;
        end else if (clk_en_in) begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;
endmodule

// file: tb.sv
/*
 * Self-checking bench for the low-power mode sequencer.
 * Assumes a 50 MHz clock; inputs change at falling edges.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lpm_pkg::*;

    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic [2:0]        mreq = 3'h7;
    logic              mgo = 1'b0;
    logic              irq = 1'b0;
    logic              vref = 1'b0;
    logic              hreq = 1'b0;
    logic [1:0]        rng = 2'h2;
    logic [FREQ_W-1:0] freq = '0;
    logic              fgo = 1'b0;
    logic              ce = 1'b1;
    logic [2:0]        sel = 3'h0;
    logic              act = 1'b0;
    logic [15:0]       line;
    logic [1:0]        cmp;
    logic [2:0]        pin;
    logic              rst_n, wdg;
    logic [4:0]        cal;
    logic [3:0]        mode;
    logic              cke, pke, mse, msl, high_speed_crystal_osc, xse, ple, low_speed_crystal_osc;
    logic              rlp, roff, ret, keep, wrst, wres, busy, rej;
    logic [FREQ_W-1:0] cpu;
    int                error_cnt = 0;
    int                check_count = 0;
    int                cur_f = 4200;

    always #10 clk = ~clk;

    lpm_src lpm_src_i (.sel_in(sel), .act_in(act), .line_out(line),
        .cmp_out(cmp), .pin_out(pin), .rst_n_out(rst_n), .wdg_out(wdg),
        .cal_out(cal));

    lpm_sequencer lpm_sequencer_i (.core_clk_in(clk), .srst_in(srst),
        .clk_en_in(ce), .mode_req_in(mreq), .mode_go_in(mgo),
        .periph_irq_in(irq), .external_interrupt_line_in(line),
        .comparator_event_in(cmp), .vref_enabled_in(vref),
        .wake_pin_in(pin), .external_reset_pin_n_in(rst_n),
        .independent_watchdog_rst_in(wdg), .calendar_event_in(cal),
        .hsi_periph_req_in(hreq), .range_sel_in(rng),
        .freq_req_khz_in(freq), .freq_go_in(fgo), .mode_out(mode),
        .core_clk_en_out(cke), .periph_clk_en_out(pke),
        .multispeed_internal_osc_en_out(mse), .msi_low_speed_out(msl),
        .high_speed_internal_osc_en_out(high_speed_crystal_osc),
        .high_speed_crystal_osc_en_out(xse), .pll_en_out(ple),
        .low_speed_osc_en_out(low_speed_crystal_osc), .reg_low_power_out(rlp),
        .reg_off_out(roff), .core_retain_out(ret),
        .standby_keep_out(keep), .wake_reset_out(wrst),
        .wake_resume_out(wres), .cpu_freq_khz_out(cpu),
        .freq_busy_out(busy), .freq_reject_out(rej));

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic enter(input logic [2:0] r, input logic [3:0] st);
        @(negedge clk) begin
            mreq = r;
            mgo = 1'b1;
        end
        @(negedge clk) mgo = 1'b0;
        chk("mode", mode, st);
    endtask

    // Source 7 is the peripheral interrupt; k: 0 none, 1 resume, 2 reset
    task automatic wake(input logic [2:0] s, input int k, input int m);
        int n;
        if (s == 3'h7) irq = 1'b1;
        else begin
            sel = s;
            act = 1'b1;
        end
        n = 0;
        while (mode !== 4'h0 && n < m) begin
            @(negedge clk) n++;
        end
        chk("woke", 16'(n < m), 16'h1);
        chk("resume", 16'(wres), 16'(k == 1));
        chk("restart", 16'(wrst), 16'(k == 2));
        irq = 1'b0;
        act = 1'b0;
        if (n >= m) test_done();
        repeat (4) @(negedge clk);
    endtask

    task automatic nowake(input logic [2:0] s, input logic [3:0] st);
        sel = s;
        act = 1'b1;
        repeat (20) @(negedge clk);
        chk("stay", mode, st);
        act = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    task automatic fstep(input logic [1:0] r, input int f, input bit ok);
        int n;
        @(negedge clk) begin
            rng = r;
            freq = FREQ_W'(f);
            fgo = 1'b1;
        end
        @(negedge clk) fgo = 1'b0;
        if (ok) cur_f = f;
        chk("reject", 16'(rej), 16'(!ok));
        chk("cpu_freq", cpu, 16'(cur_f));
    endtask

    task automatic t_sleep();
        enter(3'h0, 4'h1);
        chk("clocks", {cke, pke}, 16'h1);
        wake(3'h7, 0, 10);
        enter(3'h2, 4'h3);
        chk("reg_lp", 16'(rlp), 16'h1);
        wake(3'h7, 0, 10);
        chk("reg_lp", 16'(rlp), 16'h0);
        enter(3'h1, 4'h2);
        chk("lp_run", {mse, msl, rlp}, 16'h7);
        enter(3'h7, 4'h0);
    endtask

    // Clock enable low freezes the sequencer even with a wake pending
    task automatic t_hold();
        enter(3'h0, 4'h1);
        ce = 1'b0;
        irq = 1'b1;
        repeat (5) @(negedge clk);
        chk("frozen", mode, 16'h1);
        ce = 1'b1;
        wake(3'h7, 0, 10);
    endtask

    task automatic t_stop();
        enter(3'h4, 4'h5);
        chk("osc", {cke, ple, mse, high_speed_crystal_osc, xse, low_speed_crystal_osc}, 16'h0);
        chk("reg", {rlp, ret}, 16'h3);
        hreq = 1'b1;
        repeat (2) @(negedge clk);
        chk("hsi", 16'(high_speed_crystal_osc), 16'h1);
        hreq = 1'b0;
        nowake(3'h1, 4'h5);
        wake(3'h0, 1, STOP_WAKE_CYC + 1);
        enter(3'h3, 4'h4);
        chk("osc", {cke, ple, high_speed_crystal_osc, low_speed_crystal_osc, ret}, 16'h3);
        vref = 1'b1;
        wake(3'h1, 1, STOP_WAKE_CYC + 1);
        vref = 1'b0;
    endtask

    task automatic t_standby();
        int i;
        enter(3'h6, 4'h7);
        chk("off", {roff, ret, keep}, 16'h5);
        nowake(3'h5, 4'h7);
        wake(3'h2, 2, STANDBY_WAKE_CYC + 1);
        enter(3'h6, 4'h7);
        wake(3'h3, 2, STANDBY_WAKE_CYC + 1);
        for (i = 2; i < 6; i++) begin
            enter(3'h5, 4'h6);
            chk("lso", {low_speed_crystal_osc, roff}, 16'h3);
            wake(3'(i), 2, STANDBY_WAKE_CYC + 1);
        end
    endtask

    task automatic t_freq();
        int n;
        bit gap_ok;
        fstep(2'h2, 8000, 1'b0);
        fstep(2'h0, 16000, 1'b1);
        fstep(2'h0, 32000, 1'b0);
        n = 1;
        while (busy === 1'b1 && n < 400) begin
            @(negedge clk) n++;
        end
        gap_ok = n >= FREQ_GAP_CYC - 1 && n <= FREQ_GAP_CYC;
        chk("gap", 16'(gap_ok), 16'h1);
        fstep(2'h1, 32000, 1'b0);
        fstep(2'h0, 32000, 1'b1);
        repeat (FREQ_GAP_CYC + 2) @(negedge clk);
        fstep(2'h0, 8000, 1'b0);
        fstep(2'h0, 8001, 1'b1);
    endtask

    initial begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        chk("mode", mode, 16'h0);
        chk("cpu_freq", cpu, 16'(4200));
        chk("keep", {keep, cke}, 16'h3);
        t_sleep();
        t_hold();
        t_stop();
        t_standby();
        t_freq();
        test_done();
    end
endmodule
